// >>> include/charge_pkg.sv
// Shared constants, carrier structs and state type for the charge sequencer
package charge_pkg;

   localparam int CLK_HZ        = 100_000_000;
   localparam int MS_CYCLES     = CLK_HZ / 1000;
   localparam int TERM_MS       = 4;
   localparam int TERM_CYCLES   = TERM_MS * MS_CYCLES;
   localparam int MS_PER_S      = 1000;
   localparam int PRE_TIMEOUT_H = 1;
   localparam int S_PER_H       = 3600;
   localparam int PRE_S         = PRE_TIMEOUT_H * S_PER_H;

   localparam logic [7:0] A_CHG  = 8'h00;
   localparam logic [7:0] A_LIM  = 8'h04;
   localparam logic [7:0] A_SYS  = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;

   localparam int CC_LSB      = 0;
   localparam int CV_LSB      = 8;
   localparam int EOC_LSB     = 16;
   localparam int TERM_EN_BIT = 20;
   localparam int TMR_EN_BIT  = 21;
   localparam int FTMR_LSB    = 22;
   localparam int UVLO_LSB    = 0;
   localparam int TJ_LSB      = 4;
   localparam int VFL_DIS_BIT = 6;
   localparam int NTC_SEL_LSB = 8;
   localparam int NTC_ADJ_LSB = 12;
   localparam int RST_SEL_LSB = 0;

   localparam logic [31:0] CHG_RST  = 32'h0071_280F;
   localparam logic [31:0] LIM_RST  = 32'h0000_0034;
   localparam logic [31:0] SYS_RST  = 32'h0000_0005;
   localparam logic [31:0] CHG_MASK = 32'h00FF_3F3F;
   localparam logic [31:0] LIM_MASK = 32'h0000_FF7F;
   localparam logic [31:0] SYS_MASK = 32'h0000_0007;
   localparam logic [5:0]  PRE_DIV  = 6'h05;

   typedef enum logic [2:0] {PH_IDLE, PH_PRE, PH_FAST, PH_CV, PH_DONE, PH_TIMEOUT} phase_t;

   typedef struct packed {
      logic vin_ok;
      logic above_pre;
      logic at_cv;
      logic batt_ovp;
      logic below_rech;
      logic below_uvlo;
      logic below_eoc;
      logic input_current_cap;
      logic vin_floor;
      logic sys_droop;
      logic sys_below_batt;
      logic sys_eq_batt;
      logic junction_regulation_limit;
      logic tj_shut;
      logic tj_cooled;
      logic ntc_hot;
      logic ntc_cold;
      logic ntc_warm;
      logic ntc_cool;
   } sense_t;

   typedef struct packed {
      logic       input_sw_on;
      logic       input_regulate;
      logic       battery_sw_on;
      logic       battery_full_on;
      logic       ideal_diode;
      logic       charging;
      logic       charge_reduce;
      logic       charge_done;
      logic       timeout_fault;
      logic       ovp_fault;
      logic       ntc_fault;
      logic [5:0] current_code;
      logic [5:0] voltage_code;
      logic [3:0] eoc_code;
      logic [1:0] tj_sel;
      logic [2:0] ntc_sel;
      logic [2:0] uvlo_sel;
   } drive_t;

   typedef struct packed {
      phase_t      ph;
      sense_t      sn;
      logic        pin_n;
      logic [31:0] chg;
      logic [31:0] lim;
      logic [31:0] sys;
      logic        ack;
      logic [31:0] rdat;
      logic [16:0] ms_cnt;
      logic [9:0]  s_div;
      logic [16:0] chg_s;
      logic [18:0] term_cnt;
      logic [4:0]  rst_s;
      logic        rst_off;
      logic        tsd;
      logic        supp;
      logic        ovp;
      logic        ntc_bad;
      logic        timeout;
      drive_t      drv;
   } st_t;

   // Returns {hold seconds, off seconds}; unlisted codes fall back to 16/4
   function automatic logic [9:0] rst_times(input logic [2:0] sel);
      case (sel)
         3'h0:    rst_times = {5'h08, 5'h02};
         3'h1:    rst_times = {5'h08, 5'h04};
         3'h2:    rst_times = {5'h0C, 5'h02};
         3'h4:    rst_times = {5'h10, 5'h02};
         3'h6:    rst_times = {5'h14, 5'h02};
         default: rst_times = {5'h10, 5'h04};
      endcase
   endfunction

   // Fast-charge timer length in seconds: 3, 5, 12 or 24 hours
   function automatic logic [16:0] ftmr_secs(input logic [1:0] sel);
      case (sel)
         2'h0:    ftmr_secs = 17'h02A30;
         2'h1:    ftmr_secs = 17'h04650;
         2'h2:    ftmr_secs = 17'h0A8C0;
         default: ftmr_secs = 17'h15180;
      endcase
   endfunction

endpackage

// >>> src/charge_control_sequencer.sv
// Charge phase sequencer, path switch control and Wishbone register slave
// Notes on behaviour
// - Long reset-pin low opens both path switches
// - Hold switches open, then close automatically
// - Either input limit regulates the input switch
// - System rail droop reduces charge current
// - Config bit disables input voltage floor limiting
// - Pre-charge at one fifth fast current
// - One-hour pre-charge timeout stops, flags fault
// - Above pre-charge threshold use programmed current
// - At full voltage move to voltage regulation
// - Terminate after 4 ms continuous low current
// - Termination threshold from four-bit field
// - Input limiting or thermal loop inhibits termination
// - Termination disabled never stops on low current
// - Recharge after done only with termination enabled
// - Over-voltage suspends charge until recharge level
// - Under-voltage stops battery discharge, then restores
// - Supplement mode when system falls below battery, no termination
// - Leave supplement at equal; no input, full on
// - Junction regulation limit reduces charge current
// - Thermal shutdown opens switches, releases when cooled
// - Thermistor out of range stops charging, flagged
// - Hot/cold stop; warm/cool reduce voltage, current
// - Cool/hot bounds selected by three-bit field
// - Reset timing field selects hold/off pair
// - Fast-charge safety timer starts on fast charge
module charge_control_sequencer #(
   parameter int MS_CYC   = charge_pkg::MS_CYCLES,
   parameter int TERM_CYC = charge_pkg::TERM_CYCLES,
   parameter int S_MS     = charge_pkg::MS_PER_S
) (
   input  wire logic                clock_i,
   input  wire logic                nrst_i,
   input  wire logic                reset_pin_n_i,
   input  wire charge_pkg::sense_t  sense_i,
   output charge_pkg::drive_t       drive_o,
   input  wire logic                wb_cyc_i,
   input  wire logic                wb_stb_i,
   input  wire logic                wb_we_i,
   input  wire logic [7:0]          wb_adr_i,
   input  wire logic [3:0]          wb_sel_i,
   input  wire logic [31:0]         wb_dat_i,
   output logic [31:0]              wb_dat_o,
   output logic                     wb_ack_o
);
   import charge_pkg::*;

   st_t         s;
   st_t         n;
   sense_t      f;
   logic        ms_tick;
   logic        s_tick;
   logic        in_chg;
   logic        chg_ok;
   logic        in_lim;
   logic        term_ok;
   logic        charging;
   logic        run;
   logic        bat_off;
   logic        zone;
   logic        req;
   logic [9:0]  rt;
   logic [16:0] ftmr;
   logic [5:0]  cc;
   logic [5:0]  cv;
   logic [3:0]  adj;
   logic [5:0]  base;
   logic [5:0]  vdrop;
   logic [31:0] stat;

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] w,
                                         input logic [3:0]  sel,
                                         input logic [31:0] m);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = w[8*i +: 8];
         end
      end
      return (r & m) | (o & ~m);
   endfunction

   assign f       = s.sn;
   assign ms_tick = s.ms_cnt == 17'(MS_CYC - 1);
   assign s_tick  = ms_tick && (s.s_div == 10'(S_MS - 1));
   assign rt      = rst_times(s.sys[RST_SEL_LSB +: 3]);
   assign ftmr    = ftmr_secs(s.chg[FTMR_LSB +: 2]);
   assign in_chg  = (s.ph == PH_PRE) || (s.ph == PH_FAST) || (s.ph == PH_CV);
   assign chg_ok  = f.vin_ok & ~s.rst_off & ~s.tsd;
   assign in_lim  = f.input_current_cap | (f.vin_floor & ~s.lim[VFL_DIS_BIT]);
   // Supplement, input limiting and thermal loop all mask termination
   assign term_ok = s.chg[TERM_EN_BIT] & f.at_cv & ~s.supp & ~in_lim
                    & ~f.junction_regulation_limit;
   assign charging = in_chg & chg_ok & ~s.ovp & ~s.ntc_bad;
   // Safety timers pause while charging is suspended
   assign run     = s_tick & s.chg[TMR_EN_BIT] & charging;
   assign bat_off = s.rst_off | s.tsd | (f.below_uvlo & ~f.vin_ok)
                    | (f.vin_ok & ~s.supp & ((s.ph == PH_DONE)
                    | (s.ph == PH_TIMEOUT) | s.ntc_bad));
   assign zone    = f.ntc_warm | f.ntc_cool;
   assign cc      = s.chg[CC_LSB +: 6];
   assign cv      = s.chg[CV_LSB +: 6];
   assign adj     = s.lim[NTC_ADJ_LSB +: 4];
   assign base    = (s.ph == PH_PRE) ? cc / PRE_DIV : cc;
   assign vdrop   = {2'h0, adj[3:2], 2'h0};
   assign req     = wb_cyc_i & wb_stb_i;
   assign stat    = {21'h0, charging, s.rst_off, s.tsd, s.supp, s.ntc_bad,
                     s.ovp, s.timeout, s.ph == PH_DONE, 3'(s.ph)};

   always_comb begin
      n = s;
      n.sn = sense_i;
      n.pin_n = reset_pin_n_i;
      n.ms_cnt = ms_tick ? '0 : s.ms_cnt + 17'h1;
      if (ms_tick) begin
         n.s_div = s_tick ? '0 : s.s_div + 10'h1;
      end

      // Manual reset; one extra tick so the low time always exceeds the hold
      if (s.rst_off) begin
         if (s_tick) begin
            if (s.rst_s + 5'h01 >= rt[4:0]) begin
               n.rst_off = 1'b0;
               n.rst_s = '0;
            end else begin
               n.rst_s = s.rst_s + 5'h01;
            end
         end
      end else if (s.pin_n) begin
         n.rst_s = '0;
      end else if (s_tick) begin
         if (s.rst_s >= rt[9:5]) begin
            n.rst_off = 1'b1;
            n.rst_s = '0;
         end else begin
            n.rst_s = s.rst_s + 5'h01;
         end
      end

      // Set terms win over their clear terms
      n.tsd = f.tj_shut | (s.tsd & ~f.tj_cooled);
      n.supp = f.sys_below_batt | (s.supp & ~f.sys_eq_batt);
      n.ovp = f.batt_ovp | (s.ovp & ~f.below_rech);
      n.ntc_bad = in_chg & (f.ntc_hot | f.ntc_cold);
      n.term_cnt = '0;

      case (s.ph)
         PH_IDLE: begin
            if (chg_ok && !s.timeout) begin
               n.ph = f.above_pre ? PH_FAST : PH_PRE;
               n.chg_s = '0;
            end
         end
         PH_PRE: begin
            if (f.above_pre) begin
               n.ph = PH_FAST;
               n.chg_s = '0;
            end else if (run) begin
               if (s.chg_s >= 17'(PRE_S - 1)) begin
                  n.ph = PH_TIMEOUT;
                  n.timeout = 1'b1;
               end else begin
                  n.chg_s = s.chg_s + 17'h1;
               end
            end
         end
         PH_FAST, PH_CV: begin
            if (s.ph == PH_FAST && f.at_cv) begin
               n.ph = PH_CV;
            end
            if (s.ph == PH_CV && term_ok && f.below_eoc) begin
               if (s.term_cnt >= 19'(TERM_CYC - 1)) begin
                  n.ph = PH_DONE;
               end else begin
                  n.term_cnt = s.term_cnt + 19'h1;
               end
            end
            if (run) begin
               if (s.chg_s >= ftmr - 17'h1) begin
                  n.ph = PH_TIMEOUT;
                  n.timeout = 1'b1;
               end else begin
                  n.chg_s = s.chg_s + 17'h1;
               end
            end
         end
         PH_DONE: begin
            if (f.below_rech && f.vin_ok && s.chg[TERM_EN_BIT]) begin
               n.ph = f.above_pre ? PH_FAST : PH_PRE;
               n.chg_s = '0;
            end
         end
         PH_TIMEOUT: begin
         end
         default: begin
            n.ph = PH_IDLE;
         end
      endcase
      if (!chg_ok) begin
         n.ph = PH_IDLE;
      end
      // Only an input recycle clears a timeout
      if (!f.vin_ok) begin
         n.timeout = 1'b0;
      end

      n.drv.input_sw_on = chg_ok;
      n.drv.input_regulate = in_lim;
      n.drv.charge_reduce = f.sys_droop | f.junction_regulation_limit;
      n.drv.battery_sw_on = ~bat_off;
      n.drv.battery_full_on = ~bat_off & ~f.vin_ok;
      n.drv.ideal_diode = s.supp;
      n.drv.charging = charging;
      n.drv.charge_done = s.ph == PH_DONE;
      n.drv.timeout_fault = s.timeout;
      n.drv.ovp_fault = s.ovp;
      n.drv.ntc_fault = s.ntc_bad;
      n.drv.current_code = zone ? base >> adj[1:0] : base;
      n.drv.voltage_code = (zone && cv > vdrop) ? cv - vdrop : (zone ? '0 : cv);
      n.drv.eoc_code = s.chg[EOC_LSB +: 4];
      n.drv.tj_sel = s.lim[TJ_LSB +: 2];
      n.drv.ntc_sel = s.lim[NTC_SEL_LSB +: 3];
      n.drv.uvlo_sel = s.lim[UVLO_LSB +: 3];

      // Classic Wishbone: ack one cycle after the strobe, write on the ack edge
      n.ack = req & ~s.ack;
      if (req && !s.ack) begin
         case (wb_adr_i)
            A_CHG:   n.rdat = s.chg;
            A_LIM:   n.rdat = s.lim;
            A_SYS:   n.rdat = s.sys;
            A_STAT:  n.rdat = stat;
            default: n.rdat = '0;
         endcase
      end
      if (req && s.ack && wb_we_i) begin
         case (wb_adr_i)
            A_CHG:   n.chg = merge(s.chg, wb_dat_i, wb_sel_i, CHG_MASK);
            A_LIM:   n.lim = merge(s.lim, wb_dat_i, wb_sel_i, LIM_MASK);
            A_SYS:   n.sys = merge(s.sys, wb_dat_i, wb_sel_i, SYS_MASK);
            default: n.sys = s.sys;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         s <= '0;
         s.chg <= CHG_RST;
         s.lim <= LIM_RST;
         s.sys <= SYS_RST;
         s.pin_n <= 1'b1;
      end else begin
         s <= n;
      end
   end

   assign drive_o  = s.drv;
   assign wb_dat_o = s.rdat;
   assign wb_ack_o = s.ack;

endmodule

// >>> test/charge_checker_properties.sv
// Port-level checks for the charge sequencer
module charge_checker_properties
   import charge_pkg::*;
(
   input wire logic               clock_i,
   input wire logic               nrst_i,
   input wire logic               reset_pin_n_i,
   input wire charge_pkg::sense_t sense_i,
   input wire charge_pkg::drive_t drive_o,
   input wire logic               wb_cyc_i,
   input wire logic               wb_stb_i,
   input wire logic               wb_ack_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   // Four samples cover the sense register, the fault flag register and the drive register
   tsd_open_a: assert property (sense_i.tj_shut [*4] |->
      !drive_o.input_sw_on && !drive_o.battery_sw_on) else $error("switch on in shutdown");
   ovp_stop_a: assert property (sense_i.batt_ovp [*4] |-> !drive_o.charging)
      else $error("charging during over-voltage");
   hot_stop_a: assert property (sense_i.ntc_hot [*4] |-> !drive_o.charging)
      else $error("charging in hot zone");
   iin_reg_a: assert property (sense_i.input_current_cap [*3] |->
      drive_o.input_regulate || !drive_o.input_sw_on) else $error("input not regulated");
   droop_cut_a: assert property (sense_i.sys_droop [*4] |->
      drive_o.charge_reduce || !drive_o.charging) else $error("no cut on rail droop");
   term_block_a: assert property (sense_i.input_current_cap [*4] |->
      !$rose(drive_o.charge_done)) else $error("termination while limiting");
   done_cause_a: assert property ($rose(drive_o.charge_done) |->
      $past(sense_i.below_eoc, 3)) else $error("done without low current");
   ack_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");

   done_c: cover property ($rose(drive_o.charge_done));
   manual_c: cover property (!reset_pin_n_i && $fell(drive_o.input_sw_on));
   ack_c: cover property (wb_ack_o);
endmodule

bind charge_control_sequencer charge_checker_properties i_chk (
   .clock_i(clock_i), .nrst_i(nrst_i), .reset_pin_n_i(reset_pin_n_i), .sense_i(sense_i),
   .drive_o(drive_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// >>> test/host_pin_model.sv
// Host side of the reset-capable interrupt pin
module host_pin_model (
   input  wire logic clock_i,
   output logic      reset_pin_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Pulled up while the host leaves it alone
   initial reset_pin_n_o = 1'b1;
   task automatic drive_pin(input logic level);
      @(posedge clock_i);
      reset_pin_n_o <= level;
   endtask
endmodule

// >>> test/tb_top.sv
// Self-checking bench for the charge sequencer
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import charge_pkg::*;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        pin_n;
   sense_t      sn = '0;
   drive_t      drv;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic        ack;
   int          fail_count = 0;
   int          comparisons = 0;

   always #5 clock_i = ~clock_i;

   host_pin_model i_host (.clock_i(clock_i), .reset_pin_n_o(pin_n));
   // Shortened counts: one second is 40 cycles, termination 20 cycles
   charge_control_sequencer #(.MS_CYC(10), .TERM_CYC(20), .S_MS(4)) i_dut (
      .clock_i(clock_i), .nrst_i(nrst_i), .reset_pin_n_i(pin_n), .sense_i(sn), .drive_o(drv),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

   task automatic end_sim();
      $display("Comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk_bit(input string name, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock_i);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clock_i);
         n++;
      end while (ack !== 1'b1 && n < 50);
      chk_bit("bus ack", 1'b1, ack);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clock_i);
   endtask
   task automatic recharge();
      sn.at_cv <= 1'b0;
      sn.below_eoc <= 1'b0;
      sn.below_rech <= 1'b1;
      step(8);
      chk_bit("recharge", 1'b1, drv.charging);
      sn.below_rech <= 1'b0;
   endtask

   task automatic t_regs();
      bus(0, A_CHG, 32'h0000_0000, 4'hF);
      chk_word("chg reset", CHG_RST, rd);
      bus(0, A_LIM, 32'h0000_0000, 4'hF);
      chk_word("lim reset", LIM_RST, rd);
      bus(0, A_SYS, 32'h0000_0000, 4'hF);
      chk_word("sys reset", SYS_RST, rd);
      bus(1, A_CHG, 32'hFFFF_FFFF, 4'h1);
      bus(0, A_CHG, 32'h0000_0000, 4'hF);
      chk_word("chg lane write", CHG_RST | 32'h0000_003F, rd);
      bus(1, A_CHG, CHG_RST, 4'hF);
      bus(0, 8'h10, 32'h0000_0000, 4'hF);
      chk_word("unmapped read", 32'h0000_0000, rd);
   endtask
   task automatic t_charge();
      sn.vin_ok <= 1'b1;
      step(6);
      chk_word("pre current", 32'(6'h0F / 6'h05), 32'(drv.current_code));
      sn.above_pre <= 1'b1;
      step(6);
      chk_word("fast current", 32'h0000_000F, 32'(drv.current_code));
      bus(0, A_STAT, 32'h0000_0000, 4'hF);
      chk_word("fast phase", 32'(PH_FAST), 32'(rd[2:0]));
      sn.at_cv <= 1'b1;
      step(6);
      chk_word("cv voltage", 32'h0000_0028, 32'(drv.voltage_code));
      bus(0, A_STAT, 32'h0000_0000, 4'hF);
      chk_word("cv phase", 32'(PH_CV), 32'(rd[2:0]));
      // A dip shorter than the termination span must not finish the charge
      sn.below_eoc <= 1'b1;
      step(12);
      sn.below_eoc <= 1'b0;
      step(4);
      chk_bit("early done", 1'b0, drv.charge_done);
      sn.below_eoc <= 1'b1;
      step(30);
      chk_bit("done", 1'b1, drv.charge_done);
      chk_bit("done battery", 1'b0, drv.battery_sw_on);
      recharge();
   endtask
   task automatic t_term_block();
      bus(1, A_CHG, 32'h0061_0000, 4'h4);
      sn.at_cv <= 1'b1;
      sn.below_eoc <= 1'b1;
      step(40);
      chk_bit("no term done", 1'b0, drv.charge_done);
      chk_bit("no term charging", 1'b1, drv.charging);
      sn.input_current_cap <= 1'b1;
      bus(1, A_CHG, CHG_RST, 4'hF);
      step(40);
      chk_bit("limit done", 1'b0, drv.charge_done);
      chk_bit("limit regulate", 1'b1, drv.input_regulate);
      sn.input_current_cap <= 1'b0;
      step(30);
      chk_bit("late done", 1'b1, drv.charge_done);
      recharge();
   endtask
   task automatic t_faults();
      sn.batt_ovp <= 1'b1;
      step(6);
      chk_bit("ovp charging", 1'b0, drv.charging);
      chk_bit("ovp fault", 1'b1, drv.ovp_fault);
      sn.batt_ovp <= 1'b0;
      step(6);
      chk_bit("ovp held", 1'b0, drv.charging);
      recharge();
      sn.ntc_hot <= 1'b1;
      step(6);
      chk_bit("hot charging", 1'b0, drv.charging);
      chk_bit("hot flag", 1'b1, drv.ntc_fault);
      sn.ntc_hot <= 1'b0;
      step(6);
      chk_bit("hot resume", 1'b1, drv.charging);
      sn.tj_shut <= 1'b1;
      step(6);
      chk_bit("tsd battery", 1'b0, drv.battery_sw_on);
      sn.tj_shut <= 1'b0;
      sn.tj_cooled <= 1'b1;
      step(6);
      chk_bit("tsd release", 1'b1, drv.input_sw_on);
      sn.tj_cooled <= 1'b0;
   endtask
   task automatic t_limits();
      sn.vin_floor <= 1'b1;
      step(4);
      chk_bit("floor regulate", 1'b1, drv.input_regulate);
      bus(1, A_LIM, LIM_RST | (32'h0000_0001 << VFL_DIS_BIT), 4'hF);
      step(4);
      chk_bit("floor disabled", 1'b0, drv.input_regulate);
      bus(1, A_LIM, LIM_RST, 4'hF);
      sn.vin_floor <= 1'b0;
      sn.sys_droop <= 1'b1;
      step(4);
      chk_bit("droop reduce", 1'b1, drv.charge_reduce);
      sn.sys_droop <= 1'b0;
      sn.junction_regulation_limit <= 1'b1;
      step(4);
      chk_bit("tj reduce", 1'b1, drv.charge_reduce);
      sn.junction_regulation_limit <= 1'b0;
      step(4);
      chk_bit("reduce release", 1'b0, drv.charge_reduce);
      sn.sys_below_batt <= 1'b1;
      step(4);
      chk_bit("supplement on", 1'b1, drv.ideal_diode);
      sn.sys_below_batt <= 1'b0;
      step(4);
      chk_bit("supplement held", 1'b1, drv.ideal_diode);
      sn.sys_eq_batt <= 1'b1;
      step(4);
      chk_bit("supplement off", 1'b0, drv.ideal_diode);
      sn.sys_eq_batt <= 1'b0;
   endtask
   task automatic t_zones();
      // Adjust 5: current halved, voltage four codes lower; cool/hot select 3
      sn.ntc_warm <= 1'b1;
      bus(1, A_LIM, LIM_RST | 32'h0000_5300, 4'hF);
      step(4);
      chk_word("warm current", 32'h0000_0007, 32'(drv.current_code));
      chk_word("warm voltage", 32'h0000_0024, 32'(drv.voltage_code));
      chk_word("cool select", 32'h0000_0003, 32'(drv.ntc_sel));
      sn.ntc_warm <= 1'b0;
      sn.ntc_cool <= 1'b1;
      step(4);
      chk_word("cool current", 32'h0000_0007, 32'(drv.current_code));
      sn.ntc_cool <= 1'b0;
      bus(1, A_LIM, LIM_RST, 4'hF);
      chk_word("uvlo select", 32'h0000_0004, 32'(drv.uvlo_sel));
      chk_word("tj select", 32'h0000_0003, 32'(drv.tj_sel));
      chk_word("eoc code", 32'h0000_0001, 32'(drv.eoc_code));
      sn.ntc_cold <= 1'b1;
      step(6);
      chk_bit("cold charging", 1'b0, drv.charging);
      sn.ntc_cold <= 1'b0;
      step(6);
      chk_bit("cold resume", 1'b1, drv.charging);
      sn.vin_ok <= 1'b0;
      sn.below_uvlo <= 1'b1;
      step(4);
      chk_bit("uvlo battery", 1'b0, drv.battery_sw_on);
      sn.below_uvlo <= 1'b0;
      step(4);
      chk_bit("uvlo restore", 1'b1, drv.battery_sw_on);
      chk_bit("battery full on", 1'b1, drv.battery_full_on);
      sn.vin_ok <= 1'b1;
      step(4);
   endtask
   task automatic t_manual();
      int n;
      n = 0;
      bus(1, A_SYS, 32'h0000_0000, 4'h1);
      i_host.drive_pin(1'b0);
      step(200);
      i_host.drive_pin(1'b1);
      step(300);
      chk_bit("early release", 1'b1, drv.input_sw_on);
      i_host.drive_pin(1'b0);
      while (drv.input_sw_on === 1'b1 && n < 500) begin
         step(1);
         n++;
      end
      // Eight seconds of 40 cycles, plus up to one second of prescaler slack
      chk_bit("hold time", 1'b1, n >= 315 && n <= 370);
      chk_bit("hold battery", 1'b0, drv.battery_sw_on);
      i_host.drive_pin(1'b1);
      n = 0;
      while (drv.input_sw_on !== 1'b1 && n < 300) begin
         step(1);
         n++;
      end
      chk_bit("off time", 1'b1, n >= 75 && n <= 125);
      bus(1, A_SYS, SYS_RST, 4'hF);
   endtask

   initial begin
      step(5);
      nrst_i <= 1'b1;
      t_regs();
      t_charge();
      t_term_block();
      t_faults();
      t_limits();
      t_zones();
      t_manual();
      end_sim();
   end
   initial begin
      step(20000);
      fail_count++;
      $display("MISMATCH watchdog expected finish seen timeout");
      end_sim();
   end
endmodule
